// file: line_driver_model.sv
`timescale 1ns/1ps
`default_nettype none
// Turns shaped samples into the signed level the cable driver puts out.
module line_driver_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        srst,
  // Samples from the shaper.
  input  wire logic [6:0]  sample,
  input  wire logic        active,
  // Drive level on the cable.
  output logic signed [7:0] level
);
  // Registers the drive level; a quiet line sits at zero.
  always_ff @(posedge clk) begin
    if (srst || !active) begin
      level <= 8'sh00;
    end else begin
      level <= sample[6] ? -$signed({2'b00, sample[5:0]}) : $signed({2'b00, sample[5:0]});
    end
  end
endmodule : line_driver_model
`default_nettype wire

// file: pulse_shaper_top.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_shaper_top (
  // Clock and reset.
  input  wire logic       CLK,
  input  wire logic       SRST,
  // Register port.
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Pulse requests from the encoder.
  input  wire logic       PULSE_START,
  input  wire logic       PULSE_NEG,
  input  wire logic       SUBPHASE_TICK,
  // Shaped samples toward the line driver.
  output logic [shaper_pkg::SAMPLE_W-1:0] LINE_SAMPLE,
  output logic            LINE_ACTIVE,
  output logic      [1:0] LBO_GRADE
);
  import shaper_pkg::*;

  sample_mem_if mem ();

  logic [3:0]          pulse_shape_select;
  logic [5:0]          amplitude_scale;
  logic                ref_t1;
  logic [1:0]          unit_interval_index;
  logic [3:0]          sub_phase_index;
  logic                read_dir;
  logic                trigger;
  logic [SAMPLE_W-1:0] sample_amplitude_value;
  access_state_t       acc_state;
  access_state_t       next_acc_state;
  logic                active;
  logic                neg;
  logic [RAM_AW-1:0]   pos;
  mode_t               mode;
  logic [5:0]          std_scale;
  logic [3:0]          step_pct;
  logic [SAMPLE_W-1:0] raw;
  logic [MAG_W-1:0]    mag;
  logic [SAMPLE_W-1:0] next_line;
  logic                wr_shape;
  logic                wr_scale;
  logic                wr_access;
  logic                wr_data;
  logic                wr_ref;

  waveform_ram u_ram (
    .clk (CLK),
    .mem (mem.ram)
  );

  template_rom u_rom (
    .mem (mem.rom)
  );

  // Register write decode.
  assign wr_shape  = WR && (ADDR == OFS_SHAPE);
  assign wr_scale  = WR && (ADDR == OFS_SCALE);
  assign wr_access = WR && (ADDR == OFS_ACCESS);
  assign wr_data   = WR && (ADDR == OFS_DATA);
  assign wr_ref    = WR && (ADDR == OFS_REFCLASS);

  // Shape code, scale and reference class.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pulse_shape_select <= RST_SHAPE;
      amplitude_scale    <= RST_SCALE;
      ref_t1             <= RST_REFCLASS;
    end else begin
      if (wr_shape) begin
        pulse_shape_select <= WDATA[3:0];
      end
      if (wr_scale) begin
        amplitude_scale <= WDATA[5:0];
      end
      if (wr_ref) begin
        ref_t1 <= WDATA[0];
      end
    end
  end

  // Sample address and transfer direction.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      unit_interval_index <= 2'h0;
      sub_phase_index     <= 4'h0;
      read_dir            <= 1'h0;
    end else if (wr_access) begin
      unit_interval_index <= WDATA[ACC_UI_LSB +: 2];
      sub_phase_index     <= WDATA[ACC_SUB_LSB +: 4];
      read_dir            <= WDATA[ACC_DIR_BIT];
    end
  end

  // Trigger: a new request in the completing cycle is kept.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      trigger <= 1'h0;
    end else if (wr_access && WDATA[ACC_TRIG_BIT]) begin
      trigger <= 1'h1;
    end else if (acc_state == ACC_FINISH) begin
      trigger <= 1'h0;
    end
  end

  // Access sequencer: RAM cycle, then completion.
  always_comb begin
    next_acc_state = acc_state;
    case (acc_state)
      ACC_IDLE:   if (trigger) next_acc_state = ACC_RUN;
      ACC_RUN:    next_acc_state = ACC_FINISH;
      ACC_FINISH: next_acc_state = ACC_IDLE;
      default:    next_acc_state = ACC_IDLE;
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      acc_state <= ACC_IDLE;
    end else begin
      acc_state <= next_acc_state;
    end
  end

  // RAM software port driven from the access fields.
  assign mem.acc_addr  = {unit_interval_index, sub_phase_index};
  assign mem.acc_we    = (acc_state == ACC_RUN) && !read_dir;
  assign mem.acc_wdata = sample_amplitude_value;

  // Sample data: software writes, or RAM contents after a read.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sample_amplitude_value <= 7'h00;
    end else if (wr_data) begin
      sample_amplitude_value <= WDATA[SAMPLE_W-1:0];
    end else if (acc_state == ACC_FINISH && read_dir) begin
      sample_amplitude_value <= mem.acc_rdata;
    end
  end

  // Pulse playback position over four intervals of sixteen steps.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      active <= 1'h0;
      neg    <= 1'h0;
      pos    <= 6'h00;
    end else if (PULSE_START) begin
      active <= 1'h1;
      neg    <= PULSE_NEG;
      pos    <= 6'h00;
    end else if (active && SUBPHASE_TICK) begin
      if (pos == 6'h3F) begin
        active <= 1'h0;
      end
      pos <= pos + 6'h01;
    end
  end

  // Shape decode and the reference used for scaling.
  assign mode          = shape_mode(pulse_shape_select);
  assign mem.tmpl      = shape_template(pulse_shape_select);
  assign mem.play_addr = pos;
  assign std_scale     = ref_t1 ? STD_SCALE_T1 : STD_SCALE_E1;
  assign step_pct      = ref_t1 ? STEP_PCT_T1 : STEP_PCT_E1;

  // Source select and amplitude scaling of programmed samples.
  always_comb begin
    logic signed [7:0]  scale_diff;
    logic signed [11:0] factor;
    logic [13:0]        prod;
    logic [13:0]        quot;
    scale_diff = $signed({2'h0, amplitude_scale}) - $signed({2'h0, std_scale});
    factor     = 12'sh064 + (12'(scale_diff) * $signed({8'h00, step_pct}));
    raw        = 7'h00;
    case (mode)
      MODE_PROG:                raw = mem.play_ram;
      MODE_PRESET, MODE_LBO:    raw = mem.play_rom;
      default:                  raw = 7'h00;
    endcase
    prod = 14'(raw[MAG_W-1:0]) * (factor[11] ? 14'h0000 : 14'(factor[7:0]));
    quot = prod / 14'h0064;
    if (mode != MODE_PROG) begin
      mag = raw[MAG_W-1:0];
    end else if (quot > 14'(MAG_MAX)) begin
      mag = MAG_MAX;
    end else begin
      mag = quot[MAG_W-1:0];
    end
    if (!active || mag == 6'h00) begin
      next_line = 7'h00;
    end else begin
      next_line = {raw[SAMPLE_W-1] ^ neg, mag};
    end
  end

  // Line outputs.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      LINE_SAMPLE <= 7'h00;
      LINE_ACTIVE <= 1'h0;
      LBO_GRADE   <= 2'h0;
    end else begin
      LINE_SAMPLE <= next_line;
      LINE_ACTIVE <= active;
      LBO_GRADE   <= lbo_grade(pulse_shape_select);
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge CLK) begin
    if (SRST || !RD) begin
      RDATA <= 8'h00;
    end else begin
      case (ADDR)
        OFS_SHAPE:    RDATA <= {4'h0, pulse_shape_select};
        OFS_SCALE:    RDATA <= {2'h0, amplitude_scale};
        OFS_ACCESS:   RDATA <= {trigger, read_dir, sub_phase_index, unit_interval_index};
        OFS_DATA:     RDATA <= {1'h0, sample_amplitude_value};
        OFS_REFCLASS: RDATA <= {7'h00, ref_t1};
        OFS_STATUS:   RDATA <= {4'h0, trigger, active, mode};
        OFS_STDSCALE: RDATA <= {2'h0, std_scale};
        default:      RDATA <= 8'h00;
      endcase
    end
  end

endmodule : pulse_shaper_top
`default_nettype wire

// file: pulse_shaper_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the shaper's top ports for register and playback timing.
module pulse_shaper_checker (
  // Clock and reset.
  input wire logic                          CLK,
  input wire logic                          SRST,
  // Register port.
  input wire logic [7:0]                    ADDR,
  input wire logic [7:0]                    WDATA,
  input wire logic                          WR,
  input wire logic                          RD,
  input wire logic [7:0]                    RDATA,
  // Pulse requests.
  input wire logic                          PULSE_START,
  input wire logic                          PULSE_NEG,
  input wire logic                          SUBPHASE_TICK,
  // Shaped output.
  input wire logic [shaper_pkg::SAMPLE_W-1:0] LINE_SAMPLE,
  input wire logic                          LINE_ACTIVE,
  input wire logic [1:0]                    LBO_GRADE
);
  import shaper_pkg::*;
  logic [3:0] shape;
  logic       refc;
  logic [1:0] age;
  logic [6:0] ticks;
  logic [1:0] grade;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // Shadows the shape and class registers; age counts cycles since a shape write.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      shape <= 4'h0;
      refc  <= 1'b0;
      age   <= 2'h0;
    end else begin
      if (WR && ADDR == OFS_SHAPE) begin
        shape <= WDATA[3:0];
      end
      if (WR && ADDR == OFS_REFCLASS) begin
        refc <= WDATA[0];
      end
      age <= (WR && ADDR == OFS_SHAPE) ? 2'h0 : (age == 2'h2) ? age : age + 2'h1;
    end
  end

  // Counts ticks since the last pulse start, saturating at a full pulse.
  always_ff @(posedge CLK) begin
    if (SRST || PULSE_START) begin
      ticks <= 7'h00;
    end else if (SUBPHASE_TICK && ticks != 7'h40) begin
      ticks <= ticks + 7'h01;
    end
  end

  // Attenuation grade expected for the shadowed code.
  assign grade = (shape[3:2] == 2'h2 && shape[1:0] != 2'h0) ? shape[1:0] : 2'h0;

  a_read_data_window: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its cycle");
  a_std_scale_read: assert property ($past(RD) && $past(ADDR) == OFS_STDSCALE |-> RDATA == (refc ? 8'h36 : 8'h21))
    else $error("standard scale value wrong");
  a_idle_line_quiet: assert property (!LINE_ACTIVE |-> LINE_SAMPLE == 7'h00)
    else $error("sample while idle");
  a_no_negative_zero: assert property (LINE_SAMPLE != 7'h40)
    else $error("negative zero sample");
  a_start_drives_line: assert property (PULSE_START |-> ##2 LINE_ACTIVE)
    else $error("pulse did not start");
  a_idle_stays_idle: assert property (!LINE_ACTIVE && !PULSE_START && !$past(PULSE_START) |=> !LINE_ACTIVE)
    else $error("line active without start");
  a_pulse_length: assert property (ticks == 7'h40 && !PULSE_START |=> !LINE_ACTIVE)
    else $error("pulse longer than four intervals");
  a_lbo_follows_shape: assert property (age == 2'h2 |-> LBO_GRADE == grade)
    else $error("attenuation grade wrong");

  c_pulse: cover property (PULSE_START ##2 LINE_ACTIVE);
  c_full_pulse: cover property (ticks == 7'h40);
  c_deep_lbo: cover property (LBO_GRADE == 2'h3);
endmodule : pulse_shaper_checker

bind pulse_shaper_top pulse_shaper_checker chk_u (.CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .PULSE_START,
  .PULSE_NEG, .SUBPHASE_TICK, .LINE_SAMPLE, .LINE_ACTIVE, .LBO_GRADE);
`default_nettype wire

// file: sample_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
// Ties the controller to its sample RAM and template ROM.
interface sample_mem_if;
  import shaper_pkg::*;
  logic [RAM_AW-1:0]   acc_addr;
  logic                acc_we;
  logic [SAMPLE_W-1:0] acc_wdata;
  logic [SAMPLE_W-1:0] acc_rdata;
  logic [RAM_AW-1:0]   play_addr;
  logic [SAMPLE_W-1:0] play_ram;
  tmpl_t               tmpl;
  logic [SAMPLE_W-1:0] play_rom;
  modport ctrl (output acc_addr, acc_we, acc_wdata, play_addr, tmpl,
                input  acc_rdata, play_ram, play_rom);
  modport ram  (input  acc_addr, acc_we, acc_wdata, play_addr,
                output acc_rdata, play_ram);
  modport rom  (input  play_addr, tmpl, output play_rom);
endinterface : sample_mem_if
`default_nettype wire

// file: shaper_pkg.sv
package shaper_pkg;

  localparam int SAMPLE_W = 7;
  localparam int MAG_W    = 6;
  localparam int RAM_AW   = 6;

  // Register offsets.
  localparam logic [7:0] OFS_SHAPE    = 8'h00;
  localparam logic [7:0] OFS_SCALE    = 8'h01;
  localparam logic [7:0] OFS_ACCESS   = 8'h02;
  localparam logic [7:0] OFS_DATA     = 8'h03;
  localparam logic [7:0] OFS_REFCLASS = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h05;
  localparam logic [7:0] OFS_STDSCALE = 8'h06;

  // Field positions.
  localparam int ACC_UI_LSB   = 0;
  localparam int ACC_SUB_LSB  = 2;
  localparam int ACC_DIR_BIT  = 6;
  localparam int ACC_TRIG_BIT = 7;

  // Reset values.
  localparam logic [3:0] RST_SHAPE    = 4'h0;
  localparam logic [5:0] RST_SCALE    = 6'h21;
  localparam logic       RST_REFCLASS = 1'h0;

  // Reference scaling values and step sizes in percent.
  localparam logic [5:0] STD_SCALE_E1 = 6'h21;
  localparam logic [5:0] STD_SCALE_T1 = 6'h36;
  localparam logic [3:0] STEP_PCT_E1  = 4'h3;
  localparam logic [3:0] STEP_PCT_T1  = 4'h2;
  localparam logic [5:0] MAG_MAX      = 6'h3F;

  // Pulse-shape codes.
  localparam logic [3:0] SHAPE_E1_75  = 4'h0;
  localparam logic [3:0] SHAPE_E1_120 = 4'h1;
  localparam logic [3:0] SHAPE_T1_G1  = 4'h2;
  localparam logic [3:0] SHAPE_T1_G2  = 4'h3;
  localparam logic [3:0] SHAPE_T1_G3  = 4'h4;
  localparam logic [3:0] SHAPE_T1_G4  = 4'h5;
  localparam logic [3:0] SHAPE_T1_G5  = 4'h6;
  localparam logic [3:0] SHAPE_LBO_1  = 4'h9;
  localparam logic [3:0] SHAPE_LBO_2  = 4'hA;
  localparam logic [3:0] SHAPE_LBO_3  = 4'hB;
  localparam logic [1:0] SHAPE_PROG   = 2'h3;

  typedef enum logic [1:0] {MODE_PRESET, MODE_LBO, MODE_PROG, MODE_RESERVED} mode_t;
  typedef enum logic [2:0] {TMPL_E1_75, TMPL_E1_120, TMPL_T1_G1, TMPL_T1_G2,
                            TMPL_T1_G3, TMPL_T1_G4, TMPL_T1_G5, TMPL_NONE} tmpl_t;
  typedef enum logic [1:0] {ACC_IDLE, ACC_RUN, ACC_FINISH} access_state_t;

  // Classifies a pulse-shape code into its way of shaping.
  function automatic mode_t shape_mode(input logic [3:0] code);
    if (code[3:2] == SHAPE_PROG) begin
      return MODE_PROG;
    end
    case (code)
      SHAPE_E1_75, SHAPE_E1_120, SHAPE_T1_G1, SHAPE_T1_G2,
      SHAPE_T1_G3, SHAPE_T1_G4, SHAPE_T1_G5: return MODE_PRESET;
      SHAPE_LBO_1, SHAPE_LBO_2, SHAPE_LBO_3: return MODE_LBO;
      default: return MODE_RESERVED;
    endcase
  endfunction : shape_mode

  // Picks the ROM template for a preset or attenuated code.
  function automatic tmpl_t shape_template(input logic [3:0] code);
    case (code)
      SHAPE_E1_75:  return TMPL_E1_75;
      SHAPE_E1_120: return TMPL_E1_120;
      SHAPE_T1_G1, SHAPE_LBO_1, SHAPE_LBO_2, SHAPE_LBO_3: return TMPL_T1_G1;
      SHAPE_T1_G2:  return TMPL_T1_G2;
      SHAPE_T1_G3:  return TMPL_T1_G3;
      SHAPE_T1_G4:  return TMPL_T1_G4;
      SHAPE_T1_G5:  return TMPL_T1_G5;
      default:      return TMPL_NONE;
    endcase
  endfunction : shape_template

  // Attenuation grade for the build-out filter, 0 for none.
  function automatic logic [1:0] lbo_grade(input logic [3:0] code);
    case (code)
      SHAPE_LBO_1: return 2'h1;
      SHAPE_LBO_2: return 2'h2;
      SHAPE_LBO_3: return 2'h3;
      default:     return 2'h0;
    endcase
  endfunction : lbo_grade

endpackage : shaper_pkg

// file: template_rom.sv
`timescale 1ns/1ps
`default_nettype none
module template_rom (
  // ROM side of the sample interface.
  sample_mem_if.rom mem
);
  import shaper_pkg::*;

  // First interval of the five T1 cable grades, sub-phase 0 first.
  localparam logic [SAMPLE_W-1:0] T1_FIRST [5][16] = '{
    '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24,
      7'h23, 7'h4A, 7'h4A, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43},
    '{7'h1B, 7'h2C, 7'h2B, 7'h2A, 7'h28, 7'h28, 7'h27, 7'h26,
      7'h25, 7'h50, 7'h4F, 7'h4D, 7'h4A, 7'h48, 7'h46, 7'h44},
    '{7'h1F, 7'h31, 7'h2F, 7'h2C, 7'h2B, 7'h2A, 7'h29, 7'h28,
      7'h25, 7'h57, 7'h53, 7'h50, 7'h4B, 7'h48, 7'h46, 7'h44},
    '{7'h20, 7'h38, 7'h33, 7'h2F, 7'h2E, 7'h2D, 7'h2C, 7'h2A,
      7'h28, 7'h58, 7'h58, 7'h53, 7'h4C, 7'h48, 7'h46, 7'h44},
    '{7'h20, 7'h3F, 7'h38, 7'h33, 7'h2F, 7'h2E, 7'h2D, 7'h2C,
      7'h29, 7'h5F, 7'h5E, 7'h57, 7'h4F, 7'h49, 7'h47, 7'h44}};

  // Second-interval tails of the T1 grades.
  localparam logic [SAMPLE_W-1:0] TAIL_SHORT [3] = '{7'h42, 7'h41, 7'h00};
  localparam logic [SAMPLE_W-1:0] TAIL_LONG  [3] = '{7'h43, 7'h42, 7'h41};

  // E1 pulse levels: one edge sample, then a flat top.
  localparam logic [SAMPLE_W-1:0] E1_75_EDGE  = 7'h0C;
  localparam logic [SAMPLE_W-1:0] E1_75_TOP   = 7'h30;
  localparam logic [SAMPLE_W-1:0] E1_120_EDGE = 7'h0F;
  localparam logic [SAMPLE_W-1:0] E1_120_TOP  = 7'h3C;

  logic [1:0] ui;
  logic [3:0] sub;
  logic [2:0] grade;
  assign ui    = mem.play_addr[5:4];
  assign sub   = mem.play_addr[3:0];
  assign grade = 3'(mem.tmpl) - 3'(TMPL_T1_G1);

  // Looks up the sample of the selected template.
  always_comb begin
    mem.play_rom = 7'h00;
    case (mem.tmpl)
      TMPL_E1_75, TMPL_E1_120: begin
        if (ui == 2'h0 && sub == 4'h3) begin
          mem.play_rom = (mem.tmpl == TMPL_E1_75) ? E1_75_EDGE : E1_120_EDGE;
        end else if (ui == 2'h0 && sub >= 4'h4 && sub <= 4'hB) begin
          mem.play_rom = (mem.tmpl == TMPL_E1_75) ? E1_75_TOP : E1_120_TOP;
        end
      end
      TMPL_T1_G1, TMPL_T1_G2, TMPL_T1_G3, TMPL_T1_G4, TMPL_T1_G5: begin
        if (ui == 2'h0) begin
          mem.play_rom = T1_FIRST[grade][sub];
        end else if (ui == 2'h1 && sub < 4'h3) begin
          mem.play_rom = (grade == 3'h0) ? TAIL_SHORT[sub[1:0]] : TAIL_LONG[sub[1:0]];
        end
      end
      default: mem.play_rom = 7'h00;
    endcase
  end

endmodule : template_rom
`default_nettype wire

// file: transmit_pulse_shaper_control_test.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the shaper through its register port and pulse requests and checks the answers.
module transmit_pulse_shaper_control_test;
  import shaper_pkg::*;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic [7:0]        addr = 8'h00;
  logic [7:0]        wdata = 8'h00;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              start = 1'b0;
  logic              neg = 1'b0;
  logic              tick = 1'b0;
  logic              look = 1'b0;
  logic              rdw;
  logic              lk;
  logic [7:0]        rdata;
  logic [6:0]        line_sample;
  logic              line_active;
  logic [1:0]        lbo_grade;
  logic signed [7:0] line_level;
  logic [7:0]        rd_q[$];
  string             rn_q[$];
  logic [6:0]        ln_q[$];
  logic [6:0]        ln_e;
  logic              lv_due = 1'b0;
  logic signed [7:0] lv_exp;
  logic [6:0]        ram[64];
  logic [6:0]        want[64];
  logic [7:0]        rst_val[8] = '{8'h00, 8'h21, 8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h00};
  logic [6:0]        t1g1[18] = '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24, 7'h23,
                                  7'h4A, 7'h4A, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41};
  int                fpct = 100;
  int                fail_count = 0;
  int                tests_run = 0;

  always #25 clk = ~clk;

  pulse_shaper_top dut_u (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .PULSE_START(start), .PULSE_NEG(neg), .SUBPHASE_TICK(tick), .LINE_SAMPLE(line_sample),
    .LINE_ACTIVE(line_active), .LBO_GRADE(lbo_grade));
  line_driver_model drv_u (.clk(clk), .srst(srst), .sample(line_sample), .active(line_active), .level(line_level));

  // Compares one observed value with its expectation.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // One write cycle, then an idle cycle so the strobe is never set twice at one edge.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  // One read cycle; the data are taken in the following cycle.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rd_reg

  // Notes the expected answer, then reads.
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_q.push_back(exp);
    rn_q.push_back(what);
    rd_reg(a, d);
  endtask : rd_chk

  // One indirect sample access: index, data, direction, then trigger, then poll until done.
  task automatic access(input logic [5:0] a, input logic dir, input logic [6:0] d);
    logic [7:0] v;
    wr_reg(OFS_ACCESS, {2'b00, a[3:0], a[5:4]});
    wr_reg(OFS_DATA, {1'b0, d});
    wr_reg(OFS_ACCESS, {1'b0, dir, a[3:0], a[5:4]});
    wr_reg(OFS_ACCESS, {1'b1, dir, a[3:0], a[5:4]});
    rd_chk("trigger_busy", OFS_ACCESS, {1'b1, dir, a[3:0], a[5:4]});
    for (int k = 0; k < 8; k++) begin
      rd_reg(OFS_ACCESS, v);
      if (!v[7]) break;
    end
    check("trigger_clear", {7'h00, v[7]}, 8'h00);
    if (v[7] !== 1'b0) final_report();
  endtask : access

  // Expected output sample: scaled magnitude with the pulse polarity applied.
  function automatic logic [6:0] shaped(input logic [6:0] s, input logic pn, input int f);
    int m;
    m = s[5:0] * f / 100;
    if (m > 63) m = 63;
    return (m == 0) ? 7'h00 : {s[6] ^ pn, m[5:0]};
  endfunction : shaped

  // Builds the expected playback of an E1 or first-grade T1 preset, a build-out or a reserved code.
  task automatic load_want(input logic [3:0] code);
    foreach (want[i]) want[i] = 7'h00;
    if (code < 4'h2) begin
      want[3] = code[0] ? 7'h0F : 7'h0C;
      for (int i = 4; i < 12; i++) want[i] = code[0] ? 7'h3C : 7'h30;
    end else if (code == 4'h2 || (code[3:2] == 2'h2 && code[1:0] != 2'h0)) begin
      foreach (t1g1[i]) want[i] = t1g1[i];
    end
  endtask : load_want

  // Starts a pulse and notes n samples, one tick every two cycles; the rest of the pulse is ticked out.
  task automatic play(input logic pn, input int n);
    start <= 1'b1;
    neg   <= pn;
    @(posedge clk);
    start <= 1'b0;
    look  <= 1'b1;
    ln_q.push_back(shaped(want[0], pn, fpct));
    for (int p = 1; p < n; p++) begin
      @(posedge clk);
      look <= 1'b0;
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      look <= 1'b1;
      ln_q.push_back(shaped(want[p], pn, fpct));
    end
    @(posedge clk);
    look <= 1'b0;
    tick <= 1'b1;
    repeat (65 - n) @(posedge clk);
    tick <= 1'b0;
    @(posedge clk);
    #1 check("line_active_end", {7'h00, line_active}, 8'h00);
    @(posedge clk);
  endtask : play

  // Takes the oldest note whenever a read answer or a watched sample is due.
  always @(posedge clk) begin
    rdw = rd;
    lk  = look;
    #1;
    if (rdw && rd_q.size() > 0) check(rn_q.pop_front(), rdata, rd_q.pop_front());
    if (lv_due) check("line_level", line_level, lv_exp);
    lv_due = lk;
    if (lk) begin
      ln_e = ln_q.pop_front();
      check("line_sample", {1'b0, line_sample}, {1'b0, ln_e});
      lv_exp = {2'b00, ln_e[5:0]};
      if (ln_e[6]) lv_exp = -lv_exp;
    end
  end

  // Main sequence.
  initial begin
    logic [5:0] a;
    int         ref_std;
    void'($urandom(32'h9D3A));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 5; i < 8; i++) wr_reg(i[7:0], 8'hFF);
    foreach (rst_val[i]) rd_chk("reset_value", i[7:0], rst_val[i]);
    wr_reg(OFS_SCALE, 8'h3F);
    for (int c = 0; c < 16; c++) begin
      wr_reg(OFS_SHAPE, c[7:0]);
      rd_chk("mode", OFS_STATUS, (c >= 12) ? 8'h02 : (c >= 9) ? 8'h01 : (c <= 6) ? 8'h00 : 8'h03);
      check("lbo_grade", {6'h00, lbo_grade}, (c > 8 && c < 12) ? 8'(c - 8) : 8'h00);
      load_want(c[3:0]);
      if (c < 3 || (c > 6 && c < 12)) play(c[0], 20);
    end
    for (int i = 0; i < 64; i++) begin
      ram[i] = 7'($urandom_range(127, 0));
      access(i[5:0], 1'b0, ram[i]);
    end
    for (int k = 0; k < 4; k++) begin
      a = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($urandom_range(63, 0));
      access(a, 1'b1, 7'h00);
      rd_chk("ram_readback", OFS_DATA, {1'b0, ram[a]});
    end
    want = ram;
    for (int k = 0; k < 4; k++) begin
      wr_reg(OFS_REFCLASS, {7'h00, k[1]});
      ref_std = k[1] ? 54 : 33;
      rd_chk("std_scale", OFS_STDSCALE, 8'(ref_std));
      wr_reg(OFS_SCALE, (k == 3) ? 8'h00 : 8'(ref_std + 1 - 3 * int'(k[1])));
      fpct = 100 + ((k == 3) ? -ref_std : 1 - 3 * int'(k[1])) * (k[1] ? 2 : 3);
      if (fpct < 0) fpct = 0;
      wr_reg(OFS_SHAPE, {4'h0, 2'h3, k[1:0]});
      play(1'($urandom_range(1, 0)), 64);
    end
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    srst  <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd_chk("scale_after_reset", OFS_SCALE, 8'h21);
    check("line_active_reset", {7'h00, line_active}, 8'h00);
    final_report();
  end
endmodule : transmit_pulse_shaper_control_test
`default_nettype wire

// file: waveform_ram.sv
`timescale 1ns/1ps
`default_nettype none
module waveform_ram (
  // Clock.
  input  wire logic   clk,
  // Memory side of the sample interface.
  sample_mem_if.ram   mem
);
  import shaper_pkg::*;

  logic [SAMPLE_W-1:0] store [2**RAM_AW];

  // Software port: write on request, registered read every cycle.
  always_ff @(posedge clk) begin
    if (mem.acc_we) begin
      store[mem.acc_addr] <= mem.acc_wdata;
    end
    mem.acc_rdata <= store[mem.acc_addr];
  end

  // Playback port reads without delay.
  assign mem.play_ram = store[mem.play_addr];

endmodule : waveform_ram
`default_nettype wire
